// file: verilog/ssm_defs.vh
`ifndef SSM_DEFS_VH
`define SSM_DEFS_VH

// Register byte offsets
`define SSM_REG_STOP_SEL   5'h00
`define SSM_REG_ESTOP_TQ   5'h04
`define SSM_REG_CTRL_MODE  5'h08
`define SSM_REG_ACTIVE     5'h0c
`define SSM_REG_STATUS     5'h10

// Stop selector fields in STOP_SEL and ACTIVE
`define SSM_MAINOFF_LSB    0
`define SSM_SERVOOFF_LSB   4
`define SSM_ALARM_LSB      8
`define SSM_OVERTRAVEL_LSB 12
`define SSM_SEL_W          4

// Reset values
`define SSM_STOP_SEL_RST   16'h0000
`define SSM_ESTOP_TQ_RST   10'h000
`define SSM_CTRL_MODE_RST  3'h0

// Selector codes
`define SSM_SEL_ESTOP_BRK  4'h8
`define SSM_SEL_ESTOP_FREE 4'h9
`define SSM_SEL_HOLD_LO    4'h4
`define SSM_SEL_HOLD_HI    4'h7
`define SSM_OT_FREE        4'h1
`define SSM_OT_ESTOP       4'h2

// Control mode codes
`define SSM_MODE_POS       3'h0
`define SSM_MODE_VEL       3'h1
`define SSM_MODE_TRQ       3'h2
`define SSM_MODE_POS_VEL   3'h3
`define SSM_MODE_POS_TRQ   3'h4
`define SSM_MODE_VEL_TRQ   3'h5
`define SSM_MODE_FULL      3'h6

// Active control loop codes
`define SSM_LOOP_POS       2'h0
`define SSM_LOOP_VEL       2'h1
`define SSM_LOOP_TRQ       2'h2
`define SSM_LOOP_FULL      2'h3

// Mode switch quiet time: 10 ms of 50 ns cycles
`define SSM_SETTLE_CYC     18'h30d40

`endif

// file: verilog/ssm_top.v
// How it works
// RL1 - Power-off selector: bit0 free-run while decelerating, bit1 free-run after standstill.
// RL2 - Servo-off uses its own selector with the same brake and free-run decode.
// RL3 - Selector 0-3, 8, 9 clears the deviation counter; 4-7 holds it.
// RL4 - Selector 8 or 9 gives emergency stop; afterwards brake for 8, free-run for 9.
// RL5 - During emergency stop torque is limited to the emergency torque limit.
// RL6 - Alarm selector 4-7: immediate-stop protections do operation A, others B.
// RL7 - Over-travel with selector 2 limits deceleration torque to emergency limit.
// RL8 - Changed selectors take effect only at the next control power-up.
// RL9 - Control mode 0 pos, 1 vel, 2 torque, 6 full-closed, 3/4/5 combined.
// RL10 - Combined modes: switch input on picks first mode, off picks second.
// RL11 - Host gives no motion command within 10 ms of a mode switch.
// RL12 - Short brake stays on whenever control power is absent.
// RL13 - Negative and positive travel inhibit inputs start the over-travel stop.
// RL14 - Never brake while drive torque is on; change only across a dead cycle.
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`include "ssm_defs.vh"

module ssm_top #(
  parameter [17:0] SETTLE_CYC = `SSM_SETTLE_CYC
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        ctrl_pwr_on,
  input  wire        main_pwr_on,
  input  wire        servo_enable_in,
  input  wire        prot_trip,
  input  wire        prot_immediate,
  input  wire        neg_travel_inhibit,
  input  wire        pos_travel_inhibit,
  input  wire        motor_stopped,
  input  wire        mode_switch_in,
  output reg         short_brake,
  output reg         free_run,
  output reg         drive_en,
  output reg         estop_active,
  output reg         torque_lim_en,
  output reg  [9:0]  torque_limit,
  output reg         dev_clear,
  output reg         dev_hold,
  output reg  [1:0]  ctrl_loop,
  output reg         mode_settling
);

  // One-hot stop phases: running, decelerating, at standstill
  localparam [2:0] ST_RUN  = 3'h1;
  localparam [2:0] ST_DEC  = 3'h2;
  localparam [2:0] ST_STOP = 3'h4;

  // Decoded stop behaviour: {estop, free_dec, free_aft, hold}
  // Codes 10 to 15 fall back to braking with the counter cleared
  function [3:0] sel_dec;
    input [3:0] sel;
    reg         is_estop;
    begin
      is_estop = (sel == `SSM_SEL_ESTOP_BRK) || (sel == `SSM_SEL_ESTOP_FREE); // RL4
      sel_dec = {is_estop,
                 ~sel[3] & sel[0],                                             // RL1
                 sel[3] ? (sel == `SSM_SEL_ESTOP_FREE) : sel[1],               // RL4
                 (sel >= `SSM_SEL_HOLD_LO) && (sel <= `SSM_SEL_HOLD_HI)};      // RL3
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  // Assert at once, let go on a clock edge so no flop sees half a reset
  reg rst_meta_q;
  reg rst_sync_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire rst_n = rst_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave
  reg  [15:0] stop_sel_q;
  reg  [9:0]  estop_tq_q;
  reg  [2:0]  ctrl_mode_q;
  reg  [15:0] act_sel_q;
  reg  [9:0]  act_tq_q;
  reg  [2:0]  act_mode_q;
  reg  [2:0]  state_q;
  reg  [31:0] rdata_d;
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire        req     = avs_read | avs_write;
  wire        accept  = req & ~avs_waitrequest;
  wire        wr_now  = accept & avs_write;

  // One wait cycle, then the answer; read data are registered with it
  // Trades one cycle per access for a registered read path
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req & avs_waitrequest & avs_read) begin
        avs_readdata <= rdata_d;
      end
    end
  end

  always @* begin
    // Unmapped offsets read as zero
    rdata_d = 32'h0000_0000;
    if (avs_address == `SSM_REG_STOP_SEL) begin
      rdata_d[15:0] = stop_sel_q;
    end else if (avs_address == `SSM_REG_ESTOP_TQ) begin
      rdata_d[9:0] = estop_tq_q;
    end else if (avs_address == `SSM_REG_CTRL_MODE) begin
      rdata_d[2:0] = ctrl_mode_q;
    end else if (avs_address == `SSM_REG_ACTIVE) begin
      rdata_d = {3'h0, act_mode_q, act_tq_q, act_sel_q};
    end else if (avs_address == `SSM_REG_STATUS) begin
      rdata_d = {19'h00000, mode_settling, ctrl_loop, dev_hold, dev_clear,
                 torque_lim_en, estop_active, drive_en, free_run,
                 short_brake, state_q};
    end
  end

  // Pending settings; unmapped and read-only writes are dropped
  wire [31:0] wmask = be_mask & avs_writedata;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_sel_q  <= `SSM_STOP_SEL_RST;
      estop_tq_q  <= `SSM_ESTOP_TQ_RST;
      ctrl_mode_q <= `SSM_CTRL_MODE_RST;
    end else if (wr_now) begin
      if (avs_address == `SSM_REG_STOP_SEL) begin
        stop_sel_q <= (stop_sel_q & ~be_mask[15:0]) | wmask[15:0];
      end else if (avs_address == `SSM_REG_ESTOP_TQ) begin
        estop_tq_q <= (estop_tq_q & ~be_mask[9:0]) | wmask[9:0];
      end else if (avs_address == `SSM_REG_CTRL_MODE) begin
        ctrl_mode_q <= (ctrl_mode_q & ~be_mask[2:0]) | wmask[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings in force: loaded at control power-up only
  // Pending flag covers a supply already up when reset lets go
  reg ctrl_pwr_q;
  reg load_pend_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_pwr_q  <= 1'b0;
      load_pend_q <= 1'b1;
      act_sel_q   <= `SSM_STOP_SEL_RST;
      act_tq_q    <= `SSM_ESTOP_TQ_RST;
      act_mode_q  <= `SSM_CTRL_MODE_RST;
    end else begin
      ctrl_pwr_q <= ctrl_pwr_on;
      // A rising control supply, or one already up when reset lets go, is when new settings apply
      if ((ctrl_pwr_on & ~ctrl_pwr_q) | (load_pend_q & ctrl_pwr_on)) begin // RL8
        act_sel_q   <= stop_sel_q;
        act_tq_q    <= estop_tq_q;
        act_mode_q  <= ctrl_mode_q;
        load_pend_q <= 1'b0;
      end
    end
  end

  wire [3:0] main_sel  = act_sel_q[`SSM_MAINOFF_LSB +: `SSM_SEL_W];
  wire [3:0] servo_sel = act_sel_q[`SSM_SERVOOFF_LSB +: `SSM_SEL_W];
  wire [3:0] alarm_sel = act_sel_q[`SSM_ALARM_LSB +: `SSM_SEL_W];
  wire [3:0] ot_sel    = act_sel_q[`SSM_OVERTRAVEL_LSB +: `SSM_SEL_W];

  ////////////////////////////////////////////////////////////////////////////
  // Stop cause selection, highest priority first
  // Only the first cause is latched; later ones wait for the next run
  wire       travel_inh = neg_travel_inhibit | pos_travel_inhibit; // RL13
  wire       any_cause  = ~main_pwr_on | prot_trip | ~servo_enable_in | travel_inh;
  reg  [3:0] cause_d;
  reg        ot_d;
  reg        ot_lim_d;
  always @* begin
    cause_d  = 4'h0;
    ot_d     = 1'b0;
    ot_lim_d = 1'b0;
    if (!main_pwr_on) begin
      cause_d = sel_dec(main_sel);                                   // RL1
    end else if (prot_trip) begin
      cause_d = sel_dec(alarm_sel);                                  // RL6
      // Operation A: immediate-capable protections stop under torque control
      if (prot_immediate && cause_d[0]) begin                        // RL6
        cause_d[3] = 1'b1;
      end
    end else if (!servo_enable_in) begin
      cause_d = sel_dec(servo_sel);                                  // RL2
    end else if (travel_inh) begin
      // Over-travel keeps torque after standstill so the axis can back out
      ot_d       = 1'b1;                                             // RL13
      ot_lim_d   = (ot_sel == `SSM_OT_ESTOP);                        // RL7
      cause_d    = {1'b0, ot_sel == `SSM_OT_FREE, 1'b0, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop sequence
  // A cause gone during deceleration still runs the stop to standstill
  reg [3:0] cause_q;
  reg       ot_q;
  reg       ot_lim_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ST_RUN;
      cause_q  <= 4'h0;
      ot_q     <= 1'b0;
      ot_lim_q <= 1'b0;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (any_cause) begin
            state_q  <= ST_DEC;
            cause_q  <= cause_d;
            ot_q     <= ot_d;
            ot_lim_q <= ot_lim_d;
          end
        end
        ST_DEC: begin
          if (motor_stopped) begin
            state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (!any_cause) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Wanted drive state before the dead-time interlock
  reg want_drive;
  reg want_brake;
  reg want_lim;
  always @* begin
    want_drive = 1'b0;
    want_brake = 1'b0;
    want_lim   = 1'b0;
    // Missing control supply overrides every selector
    if (!ctrl_pwr_on) begin
      want_brake = 1'b1;                                             // RL12
    end else if (state_q == ST_RUN) begin
      want_drive = 1'b1;
    end else if (state_q == ST_DEC) begin
      if (cause_q[3] | ot_lim_q) begin
        want_drive = 1'b1;                                           // RL4
        want_lim   = 1'b1;                                           // RL5
      end else begin
        want_brake = ~cause_q[2];                                    // RL1
      end
    end else if (ot_q) begin
      want_drive = 1'b1;
    end else begin
      want_brake = ~cause_q[1];                                      // RL1
    end
  end

  // Break before make: each side waits for the other to be off
  // Costs one coasting cycle per hand-over, never both paths on
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      short_brake   <= 1'b1;
      drive_en      <= 1'b0;
      free_run      <= 1'b0;
      estop_active  <= 1'b0;
      torque_lim_en <= 1'b0;
      torque_limit  <= `SSM_ESTOP_TQ_RST;
      dev_clear     <= 1'b0;
      dev_hold      <= 1'b0;
    end else begin
      short_brake   <= want_brake & ~drive_en;                       // RL14
      drive_en      <= want_drive & ~short_brake & ~want_brake;      // RL14
      free_run      <= ~want_brake & ~want_drive;
      estop_active  <= want_lim & ~ot_lim_q;                         // RL4
      torque_lim_en <= want_lim;                                     // RL7
      torque_limit  <= act_tq_q;                                     // RL5
      dev_clear     <= (state_q != ST_RUN) & ~cause_q[0];            // RL3
      dev_hold      <= (state_q != ST_RUN) & cause_q[0];             // RL3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control mode decode
  // Mode 7 is unused and falls back to position control
  reg [1:0] loop_d;
  wire      combo = (act_mode_q == `SSM_MODE_POS_VEL) || (act_mode_q == `SSM_MODE_POS_TRQ) ||
                    (act_mode_q == `SSM_MODE_VEL_TRQ);
  always @* begin
    loop_d = `SSM_LOOP_POS;
    case (act_mode_q)                                                // RL9
      `SSM_MODE_VEL:     loop_d = `SSM_LOOP_VEL;
      `SSM_MODE_TRQ:     loop_d = `SSM_LOOP_TRQ;
      `SSM_MODE_FULL:    loop_d = `SSM_LOOP_FULL;
      `SSM_MODE_POS_VEL: loop_d = mode_switch_in ? `SSM_LOOP_POS : `SSM_LOOP_VEL; // RL10
      `SSM_MODE_POS_TRQ: loop_d = mode_switch_in ? `SSM_LOOP_POS : `SSM_LOOP_TRQ; // RL10
      `SSM_MODE_VEL_TRQ: loop_d = mode_switch_in ? `SSM_LOOP_VEL : `SSM_LOOP_TRQ; // RL10
      default:           loop_d = `SSM_LOOP_POS;
    endcase
  end

  // Quiet window flag after a switch; the host must hold commands off
  // A bouncing switch input restarts the count and stretches the flag
  reg        mode_sw_q;
  reg [17:0] settle_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_sw_q     <= 1'b0;
      settle_q      <= 18'h00000;
      ctrl_loop     <= `SSM_LOOP_POS;
      mode_settling <= 1'b0;
    end else begin
      mode_sw_q <= mode_switch_in;
      ctrl_loop <= loop_d;
      if (combo && (mode_switch_in != mode_sw_q)) begin
        settle_q      <= SETTLE_CYC;                                 // RL11
        mode_settling <= 1'b1;
      end else if (settle_q != 18'h00000) begin
        settle_q      <= settle_q - 18'h00001;
        mode_settling <= (settle_q != 18'h00001);
      end else begin
        mode_settling <= 1'b0;
      end
    end
  end

endmodule // ssm_top

// file: tb/ssm_assertions.sv
module ssm_checker #(
  parameter [17:0] SETTLE_CYC = 18'h14
) (
  input logic clk,
  input logic nrst,
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  input logic ctrl_pwr_on,
  input logic short_brake,
  input logic free_run,
  input logic drive_en,
  input logic estop_active,
  input logic torque_lim_en,
  input logic dev_clear,
  input logic dev_hold,
  input logic mode_settling
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [17:0] settle_cnt_q;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Length of the settle window, judged when it closes
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      settle_cnt_q <= 18'h0;
    else if (mode_settling)
      settle_cnt_q <= settle_cnt_q + 18'h1;
    else
      settle_cnt_q <= 18'h0;
  end

  //////////////////////////////
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  a_brake_drive: assert property (!(short_brake && drive_en))
    else $error("brake with drive");
  a_dead_brake: assert property ($rose(short_brake) |-> !$past(drive_en))
    else $error("no dead cycle to brake");
  a_dead_drive: assert property ($rose(drive_en) |-> !$past(short_brake))
    else $error("no dead cycle to drive");
  a_pwr_brake: assert property (!ctrl_pwr_on [*5] |-> short_brake)
    else $error("no brake without power");
  a_estop_limit: assert property (estop_active |-> torque_lim_en)
    else $error("estop without limit");
  a_estop_driven: assert property (estop_active |-> !short_brake && !free_run)
    else $error("estop not driven");
  a_clear_hold: assert property (!(dev_clear && dev_hold))
    else $error("clear and hold");
  a_free_brake: assert property (!(free_run && short_brake))
    else $error("free and brake");
  a_settle_len: assert property ($fell(mode_settling) |-> settle_cnt_q == SETTLE_CYC)
    else $error("settle length");

  c_estop: cover property ($rose(estop_active));
  c_settle: cover property ($rose(mode_settling));
  c_hold_free: cover property (dev_hold && free_run);
endmodule // ssm_checker

//////////////////////////////
bind ssm_top ssm_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
  .clk(clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .ctrl_pwr_on(ctrl_pwr_on),
  .short_brake(short_brake), .free_run(free_run), .drive_en(drive_en),
  .estop_active(estop_active), .torque_lim_en(torque_lim_en), .dev_clear(dev_clear),
  .dev_hold(dev_hold), .mode_settling(mode_settling));

// file: tb/ssm_host_model.sv
module ssm_host_model #(
  parameter int QUIET_CYC = 24
) (
  input  logic clk,
  input  logic slow,
  input  logic servo_req,
  input  logic switch_req,
  output logic servo_enable_in,
  output logic mode_switch_in,
  output logic quiet_busy
);
  timeunit 1ns;
  timeprecision 1ns;

  logic servo_q;
  int   quiet_cnt = 0;

  initial begin
    servo_q = 1'b1;
    servo_enable_in = 1'b1;
    mode_switch_in = 1'b0;
  end

  // Slow host lets servo enable lag one cycle
  always @(posedge clk) begin
    servo_q <= servo_req;
    servo_enable_in <= slow ? servo_q : servo_req;
    if (quiet_cnt != 0)
      quiet_cnt <= quiet_cnt - 1;
    else if (switch_req != mode_switch_in) begin
      mode_switch_in <= switch_req;
      quiet_cnt <= QUIET_CYC;
    end
  end
  assign quiet_busy = (quiet_cnt != 0) || (switch_req != mode_switch_in);
endmodule // ssm_host_model

// file: tb/tb_stop_sequence_mode_selector.sv
`include "ssm_defs.vh"

module tb_stop_sequence_mode_selector;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [9:0] TQ = 10'h2a5;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ctrl_pwr_on = 1'b1;
  logic        main_pwr_on = 1'b1;
  logic        prot_trip = 1'b0;
  logic        prot_immediate = 1'b0;
  logic [1:0]  ot_in = 2'h0;
  logic        motor_stopped = 1'b0;
  logic        servo_req = 1'b1;
  logic        switch_req = 1'b0;
  logic        slow = 1'b0;
  logic        servo_enable_in, mode_switch_in, quiet_busy;
  logic        short_brake, free_run, drive_en, estop_active, torque_lim_en;
  logic        dev_clear, dev_hold, mode_settling;
  logic [9:0]  torque_limit;
  logic [1:0]  ctrl_loop;
  logic [4:0]  stop_vec;
  logic [31:0] rd, cur_act = 32'h0;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  assign stop_vec = {short_brake, free_run, estop_active, dev_clear, dev_hold};
  always #25 clk = ~clk;

  ssm_top #(.SETTLE_CYC(18'h14)) i_dut (
    .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ctrl_pwr_on(ctrl_pwr_on), .main_pwr_on(main_pwr_on),
    .servo_enable_in(servo_enable_in), .prot_trip(prot_trip),
    .prot_immediate(prot_immediate), .neg_travel_inhibit(ot_in[0]),
    .pos_travel_inhibit(ot_in[1]), .motor_stopped(motor_stopped),
    .mode_switch_in(mode_switch_in), .short_brake(short_brake), .free_run(free_run),
    .drive_en(drive_en), .estop_active(estop_active), .torque_lim_en(torque_lim_en),
    .torque_limit(torque_limit), .dev_clear(dev_clear), .dev_hold(dev_hold),
    .ctrl_loop(ctrl_loop), .mode_settling(mode_settling));

  ssm_host_model #(.QUIET_CYC(24)) i_host (
    .clk(clk), .slow(slow), .servo_req(servo_req), .switch_req(switch_req),
    .servo_enable_in(servo_enable_in), .mode_switch_in(mode_switch_in),
    .quiet_busy(quiet_busy));

  //////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // New settings only count after a control power cycle
  task automatic load(input logic [15:0] sel, input logic [2:0] mode);
    bus(1'b1, `SSM_REG_STOP_SEL, {16'h0, sel});
    bus(1'b1, `SSM_REG_CTRL_MODE, {29'h0, mode});
    bus(1'b1, `SSM_REG_ESTOP_TQ, {22'h0, TQ});
    bus(1'b1, `SSM_REG_ACTIVE, 32'hffffffff);
    bus(1'b0, `SSM_REG_ACTIVE, 32'h0);
    check(rd, cur_act);
    @(posedge clk) ctrl_pwr_on <= 1'b0;
    repeat (6) @(posedge clk);
    check({short_brake, drive_en}, 2'b10);
    ctrl_pwr_on <= 1'b1;
    repeat (6) @(posedge clk);
    cur_act = {3'h0, mode, TQ, sel};
    bus(1'b0, `SSM_REG_ACTIVE, 32'h0);
    check(rd, cur_act);
  endtask

  task automatic set_cause(input int c, input logic v);
    case (c)
      0: main_pwr_on <= !v;
      1: servo_req <= !v;
      2: prot_trip <= v;
      default: ot_in[c-3] <= v;
    endcase
  endtask

  function automatic logic [4:0] stop_exp(input logic [3:0] s, input logic after);
    logic hold, fr;
    hold = (s >= 4'h4 && s <= 4'h7);
    fr = after ? (s == 4'h9 || (s < 4'h8 && s[1])) : s[0];
    if (s >= 4'h8 && !after)
      return 5'b00110;
    return {!fr, fr, 1'b0, !hold, hold};
  endfunction

  task automatic stop_run(input int c, input logic [4:0] m, input logic [4:0] e_dec,
                          input logic [4:0] e_end);
    set_cause(c, 1'b1);
    repeat (8) @(posedge clk);
    check(stop_vec & m, e_dec);
    if (e_dec[2] || c > 2)
      check({torque_lim_en, torque_limit}, {1'b1, TQ});
    motor_stopped <= 1'b1;
    repeat (6) @(posedge clk);
    check(stop_vec & m, e_end);
    set_cause(c, 1'b0);
    motor_stopped <= 1'b0;
    repeat (10) @(posedge clk);
    check(drive_en, 1'b1);
  endtask

  function automatic logic [1:0] loop_exp(input int m, input logic on);
    case (m)
      3: return on ? 2'h0 : 2'h1;
      4: return on ? 2'h0 : 2'h2;
      5: return on ? 2'h1 : 2'h2;
      6: return 2'h3;
      default: return 2'(m);
    endcase
  endfunction

  //////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    check({short_brake, drive_en, avs_waitrequest}, 3'b101);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 6; a++) begin
      bus(1'b0, 5'(a * 4), 32'h0);
      check(rd, (a == 4) ? 32'h21 : 32'h0);
    end
    for (int c = 0; c < 3; c++) begin
      for (int s = 0; s < 10; s++) begin
        slow <= 1'(s);
        load({4{4'(s)}}, 3'h0);
        stop_run(c, 5'h1f, stop_exp(4'(s), 1'b0), stop_exp(4'(s), 1'b1));
      end
    end
    prot_immediate <= 1'b1;
    load(16'h4444, 3'h0);
    stop_run(2, 5'h04, 5'h04, 5'h00);
    prot_immediate <= 1'b0;
    load(16'h2222, 3'h0);
    stop_run(3, 5'h03, 5'h01, 5'h01);
    stop_run(4, 5'h03, 5'h01, 5'h01);
    for (int m = 0; m < 7; m++) begin
      load(16'h0, 3'(m));
      for (int w = 0; w < 2; w++) begin
        switch_req <= 1'(w);
        do @(posedge clk); while (quiet_busy !== 1'b0);
        repeat (2) @(posedge clk);
        check(ctrl_loop, loop_exp(m, 1'(w)));
      end
    end
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule // tb_stop_sequence_mode_selector
